// ---- core/sysbus_req_pkg.sv ----
// shared types and constants of the system bus request-phase block
package sysbus_req_pkg;

  // ----------------------------------------------------------------
  // bus field widths
  // ----------------------------------------------------------------
  localparam int ADDR_MSB   = 35;
  localparam int ADDR_LSB   = 3;
  localparam int ADDR_W     = ADDR_MSB - ADDR_LSB + 1;
  localparam int RTYPE_W    = 5;
  localparam int STB0_TOP   = 16;   // strobe 0 times addr 16..3 and the type lines
  localparam int STB1_LOW   = 17;   // strobe 1 times addr 35..17
  localparam int STB0_BITS  = STB0_TOP - ADDR_LSB + 1;
  localparam int MON_W      = 4;
  localparam int SYNC_DEPTH = 2;

  // ----------------------------------------------------------------
  // reset values of the bus pins (all deasserted, lines are active low)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0]  ADDR_IDLE  = 33'h1_ffff_ffff;
  localparam logic [RTYPE_W-1:0] RTYPE_IDLE = 5'h1f;
  localparam logic [1:0]         STB_IDLE   = 2'h3;
  localparam logic [MON_W-1:0]   MON_IDLE   = 4'hf;

  // ----------------------------------------------------------------
  // request phase carrier: sub-phase 1 address, sub-phase 2 type info
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0]  addr;
    logic [RTYPE_W-1:0] rtype;
    logic [ADDR_W-1:0]  attr;
  } bus_req_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SUB1 = 2'b01,
    ST_SUB2 = 2'b11
  } launch_st_t;

endpackage : sysbus_req_pkg

// ---- core/sysbus_request_phase.sv ----
// request-phase logic of the system bus agent: launch, snoop capture, stall, monitor lines
// Summary of operation
// - initiator drives address-valid strobe low while address and type lines hold a new request
// - every agent starts decode and snoop on seeing the address-valid strobe; this block ignores the strobe while it drives it itself
// - strobe 0 times type lines and addr 16..3, strobe 1 addr 35..17
// - the bus clock sets bus rate; all pins launch and sample on it (monitor lines 3,0 are read back on the core clock instead)
// - launch and sampling reference the rising edge of the true bus clock
// - an agent unable to accept transactions asserts the shared block-next-request line
// - while the stall line is asserted the owner starts no new transaction
// - four monitor lines report breakpoints and counters; 2,1 output, 3,0 bidirectional
// - address lines carry address in sub-phase 1, type info in sub-phase 2
`timescale 1ns/1ps
module sysbus_request_phase (
  input  wire logic                                  I_CLOCK,
  input  wire logic                                  I_RSTN,
  input  wire logic                                  I_BCLK,
  // core side request
  input  wire logic                                  I_REQ_VALID,
  input  wire sysbus_req_pkg::bus_req_t              I_REQ,
  output logic                                       O_REQ_READY,
  // core side snoop, stall and monitor
  output logic                                       O_SNOOP_VALID,
  output sysbus_req_pkg::bus_req_t                   O_SNOOP,
  input  wire logic                                  I_STALL,
  input  wire logic [sysbus_req_pkg::MON_W-1:0]      I_MONITOR,
  output logic [1:0]                                 O_MONITOR_IN,
  // bus pins
  output logic [sysbus_req_pkg::ADDR_W-1:0]          O_ADDR_N,
  output logic                                       O_ADDR_OE,
  input  wire logic [sysbus_req_pkg::ADDR_W-1:0]     I_ADDR_N,
  output logic [sysbus_req_pkg::RTYPE_W-1:0]         O_RTYPE_N,
  output logic                                       O_RTYPE_OE,
  input  wire logic [sysbus_req_pkg::RTYPE_W-1:0]    I_RTYPE_N,
  output logic                                       O_ADDR_VALID_STROBE_N,
  output logic                                       O_ADDR_VALID_STROBE_OE,
  input  wire logic                                  I_ADDR_VALID_STROBE_N,
  output logic [1:0]                                 O_ADDR_SOURCE_SYNC_STROBE_N,
  output logic                                       O_ADDR_SOURCE_SYNC_STROBE_OE,
  output logic                                       O_BLOCK_NEXT_REQUEST_N,
  output logic                                       O_BLOCK_NEXT_REQUEST_OE,
  input  wire logic                                  I_BLOCK_NEXT_REQUEST_N,
  output logic [sysbus_req_pkg::MON_W-1:0]           O_BREAKPOINT_MONITOR_N,
  output logic [1:0]                                 O_BREAKPOINT_MONITOR_OE,
  input  wire logic [1:0]                            I_BREAKPOINT_MONITOR_N
);

  // ----------------------------------------------------------------
  // reset release, one copy per clock domain
  // ----------------------------------------------------------------
  logic rst_n;
  logic brst_n;

  sysbus_sync #(.WIDTH(1), .INIT(1'h0)) u_rst_core (
    .i_clk   (I_CLOCK),
    .i_rst_n (I_RSTN),
    .i_d     (1'h1),
    .o_q     (rst_n)
  );

  sysbus_sync #(.WIDTH(1), .INIT(1'h0)) u_rst_bus (
    .i_clk   (I_BCLK),
    .i_rst_n (I_RSTN),
    .i_d     (1'h1),
    .o_q     (brst_n)
  );

  // ----------------------------------------------------------------
  // core domain: request hold register and toggle handshake
  // ----------------------------------------------------------------
  sysbus_req_pkg::bus_req_t req_q;
  logic                     req_tgl_q;
  logic                     ack_tgl_q;
  logic                     ack_tgl_core;
  logic                     snp_tgl_q;
  logic                     snp_tgl_core;
  logic                     snp_seen_q;
  sysbus_req_pkg::bus_req_t snp_q;

  wire req_idle   = (ack_tgl_core == req_tgl_q);
  wire req_take   = I_REQ_VALID && req_idle;
  wire snp_arrive = (snp_tgl_core != snp_seen_q);

  assign O_REQ_READY = req_idle;

  // held data only changes while the bus side is not reading it
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      req_q      <= '0;
      req_tgl_q  <= 1'h0;
      snp_seen_q <= 1'h0;
      O_SNOOP    <= '0;
    end else begin
      if (req_take) begin
        req_q     <= I_REQ;
        req_tgl_q <= ~req_tgl_q;
      end
      snp_seen_q <= snp_tgl_core;
      if (snp_arrive) begin
        O_SNOOP <= snp_q;
      end
    end
  end

  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      O_SNOOP_VALID <= 1'h0;
    end else begin
      O_SNOOP_VALID <= snp_arrive;
    end
  end

  sysbus_sync #(.WIDTH(1)) u_ack_sync (
    .i_clk   (I_CLOCK),
    .i_rst_n (rst_n),
    .i_d     (ack_tgl_q),
    .o_q     (ack_tgl_core)
  );

  sysbus_sync #(.WIDTH(1)) u_snp_sync (
    .i_clk   (I_CLOCK),
    .i_rst_n (rst_n),
    .i_d     (snp_tgl_q),
    .o_q     (snp_tgl_core)
  );

  sysbus_sync #(.WIDTH(2)) u_mon_in_sync (
    .i_clk   (I_CLOCK),
    .i_rst_n (rst_n),
    .i_d     (~I_BREAKPOINT_MONITOR_N),
    .o_q     (O_MONITOR_IN)
  );

  // ----------------------------------------------------------------
  // bus domain: crossings in from the core
  // ----------------------------------------------------------------
  logic                                 req_tgl_bus;
  logic                                 stall_bus;
  logic [sysbus_req_pkg::MON_W-1:0]     mon_bus;

  sysbus_sync #(.WIDTH(1)) u_req_sync (
    .i_clk   (I_BCLK),
    .i_rst_n (brst_n),
    .i_d     (req_tgl_q),
    .o_q     (req_tgl_bus)
  );

  sysbus_sync #(.WIDTH(1)) u_stall_sync (
    .i_clk   (I_BCLK),
    .i_rst_n (brst_n),
    .i_d     (I_STALL),
    .o_q     (stall_bus)
  );

  sysbus_sync #(.WIDTH(sysbus_req_pkg::MON_W)) u_mon_sync (
    .i_clk   (I_BCLK),
    .i_rst_n (brst_n),
    .i_d     (I_MONITOR),
    .o_q     (mon_bus)
  );

  // ----------------------------------------------------------------
  // bus domain: launch sequencer
  // ----------------------------------------------------------------
  sysbus_req_pkg::launch_st_t st_q;
  sysbus_req_pkg::launch_st_t st_d;

  // bus pins are synchronous to the bus clock, so they are sampled directly
  wire bus_stalled = ~I_BLOCK_NEXT_REQUEST_N;
  wire pending     = (req_tgl_bus != ack_tgl_q);
  wire launch      = pending && !bus_stalled;

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      sysbus_req_pkg::ST_IDLE: if (launch) st_d = sysbus_req_pkg::ST_SUB1;
      sysbus_req_pkg::ST_SUB1: st_d = sysbus_req_pkg::ST_SUB2;
      sysbus_req_pkg::ST_SUB2: st_d = sysbus_req_pkg::ST_IDLE;
      default:                 st_d = sysbus_req_pkg::ST_IDLE;
    endcase
  end

  wire to_sub1 = (st_d == sysbus_req_pkg::ST_SUB1);
  wire to_sub2 = (st_d == sysbus_req_pkg::ST_SUB2);
  wire driving = to_sub1 || to_sub2;

  // lines are driven inverted; an asserted bit is a low level
  wire [sysbus_req_pkg::ADDR_W-1:0] addr_d =
    to_sub1 ? ~req_q.addr : (to_sub2 ? ~req_q.attr : sysbus_req_pkg::ADDR_IDLE);
  wire [sysbus_req_pkg::RTYPE_W-1:0] rtype_d =
    driving ? ~req_q.rtype : sysbus_req_pkg::RTYPE_IDLE;

  // strobe falls with sub-phase 1 and rises with sub-phase 2: one sample per edge
  wire [1:0] stb_d = to_sub1 ? 2'h0 : sysbus_req_pkg::STB_IDLE;

  always_ff @(posedge I_BCLK or negedge brst_n) begin
    if (!brst_n) begin
      st_q      <= sysbus_req_pkg::ST_IDLE;
      ack_tgl_q <= 1'h0;
    end else begin
      st_q <= st_d;
      if (st_q == sysbus_req_pkg::ST_SUB2) begin
        ack_tgl_q <= ~ack_tgl_q;
      end
    end
  end

  always_ff @(posedge I_BCLK or negedge brst_n) begin
    if (!brst_n) begin
      O_ADDR_N                     <= sysbus_req_pkg::ADDR_IDLE;
      O_RTYPE_N                    <= sysbus_req_pkg::RTYPE_IDLE;
      O_ADDR_OE                    <= 1'h0;
      O_RTYPE_OE                   <= 1'h0;
      O_ADDR_VALID_STROBE_N        <= 1'h1;
      O_ADDR_VALID_STROBE_OE       <= 1'h0;
      O_ADDR_SOURCE_SYNC_STROBE_N  <= sysbus_req_pkg::STB_IDLE;
      O_ADDR_SOURCE_SYNC_STROBE_OE <= 1'h0;
    end else begin
      O_ADDR_N                     <= addr_d;
      O_RTYPE_N                    <= rtype_d;
      O_ADDR_OE                    <= driving;
      O_RTYPE_OE                   <= driving;
      O_ADDR_VALID_STROBE_N        <= ~to_sub1;
      O_ADDR_VALID_STROBE_OE       <= driving;
      O_ADDR_SOURCE_SYNC_STROBE_N  <= stb_d;
      O_ADDR_SOURCE_SYNC_STROBE_OE <= driving;
    end
  end

  // ----------------------------------------------------------------
  // bus domain: stall and monitor outputs
  // ----------------------------------------------------------------
  // shared line: driven low only while stalling, released otherwise
  always_ff @(posedge I_BCLK or negedge brst_n) begin
    if (!brst_n) begin
      O_BLOCK_NEXT_REQUEST_N  <= 1'h1;
      O_BLOCK_NEXT_REQUEST_OE <= 1'h0;
      O_BREAKPOINT_MONITOR_N  <= sysbus_req_pkg::MON_IDLE;
      O_BREAKPOINT_MONITOR_OE <= 2'h0;
    end else begin
      O_BLOCK_NEXT_REQUEST_N  <= ~stall_bus;
      O_BLOCK_NEXT_REQUEST_OE <= stall_bus;
      O_BREAKPOINT_MONITOR_N  <= ~mon_bus;
      O_BREAKPOINT_MONITOR_OE <= {mon_bus[3], mon_bus[0]};
    end
  end

  // ----------------------------------------------------------------
  // bus domain: snoop capture of another agent's request
  // ----------------------------------------------------------------
  // limitation: snoops closer than the core's handshake time overwrite each other
  logic rx_sub2_q;
  wire  rx_start = ~I_ADDR_VALID_STROBE_N && !O_ADDR_VALID_STROBE_OE;

  always_ff @(posedge I_BCLK or negedge brst_n) begin
    if (!brst_n) begin
      rx_sub2_q <= 1'h0;
      snp_tgl_q <= 1'h0;
      snp_q     <= '0;
    end else begin
      rx_sub2_q <= rx_start;
      if (rx_start) begin
        snp_q.addr  <= ~I_ADDR_N;
        snp_q.rtype <= ~I_RTYPE_N;
      end
      if (rx_sub2_q) begin
        snp_q.attr <= ~I_ADDR_N;
        snp_tgl_q  <= ~snp_tgl_q;
      end
    end
  end

endmodule : sysbus_request_phase

// ---- core/sysbus_sync.sv ----
// two-flop synchroniser, also used as a reset release stage
`timescale 1ns/1ps
module sysbus_sync #(
  parameter int         WIDTH = 1,
  parameter logic [0:0] INIT  = 1'h0
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic [WIDTH-1:0] i_d,
  output logic      [WIDTH-1:0] o_q
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= {WIDTH{INIT}};
      o_q    <= {WIDTH{INIT}};
    end else begin
      meta_q <= i_d;
      o_q    <= meta_q;
    end
  end

endmodule : sysbus_sync

// ---- verification/sysbus_far_agent.sv ----
// far bus agent model: issues foreign requests and stalls the bus
`timescale 1ns/1ps
module sysbus_far_agent (
  input  wire logic                                i_bclk,
  input  wire logic                                i_go,
  input  wire logic                                i_stall,
  input  wire logic                                i_stall_line_n,
  input  wire sysbus_req_pkg::bus_req_t            i_req,
  output logic                                     o_drv,
  output logic                                     o_avs_n,
  output logic                                     o_stall_n,
  output logic [sysbus_req_pkg::ADDR_W-1:0]        o_addr_n,
  output logic [sysbus_req_pkg::RTYPE_W-1:0]       o_rtype_n
);
  logic [1:0] ph_q = 2'h0;
  logic       stall_n_q = 1'b1;
  // launches only on the rising bus clock, never into a stall
  always @(posedge i_bclk) begin
    if (ph_q != 2'h0) ph_q <= (ph_q == 2'h1) ? 2'h2 : 2'h0;
    else if (i_go && i_stall_line_n) ph_q <= 2'h1;
  end
  assign o_drv     = ph_q != 2'h0;
  assign o_avs_n   = ph_q != 2'h1;
  assign o_addr_n  = (ph_q == 2'h1) ? ~i_req.addr : ~i_req.attr;
  assign o_rtype_n = ~i_req.rtype;
  // stall line moves only on the bus clock, like the drive and strobe pins; address and type pins follow i_req directly
  always @(posedge i_bclk) stall_n_q <= !i_stall;
  assign o_stall_n = stall_n_q;
endmodule : sysbus_far_agent

// ---- verification/sysbus_request_phase_checker.sv ----
// pin-level assertions of the request-phase block, bus clock domain
`timescale 1ns/1ps
module sysbus_request_phase_checker (
  input wire logic       I_BCLK,
  input wire logic       I_RSTN,
  input wire logic       I_STALL,
  input wire logic [3:0] I_MONITOR,
  input wire logic       I_BLOCK_NEXT_REQUEST_N,
  input wire logic       O_ADDR_OE,
  input wire logic       O_RTYPE_OE,
  input wire logic       O_ADDR_VALID_STROBE_N,
  input wire logic       O_ADDR_VALID_STROBE_OE,
  input wire logic [1:0] O_ADDR_SOURCE_SYNC_STROBE_N,
  input wire logic       O_ADDR_SOURCE_SYNC_STROBE_OE,
  input wire logic       O_BLOCK_NEXT_REQUEST_N,
  input wire logic       O_BLOCK_NEXT_REQUEST_OE,
  input wire logic [3:0] O_BREAKPOINT_MONITOR_N,
  input wire logic [1:0] O_BREAKPOINT_MONITOR_OE,
  input wire logic       O_SNOOP_VALID
);
  default clocking cb @(posedge I_BCLK); endclocking
  default disable iff (!I_RSTN);
  a_strobe_pulse: assert property ($fell(O_ADDR_VALID_STROBE_N) |=> O_ADDR_VALID_STROBE_N)
    else $error("address-valid strobe held too long");
  a_strobe_drives: assert property (!O_ADDR_VALID_STROBE_N |-> O_ADDR_VALID_STROBE_OE && O_ADDR_OE && O_RTYPE_OE)
    else $error("strobe low without address and type lines driven");
  a_sync_fall: assert property (!O_ADDR_VALID_STROBE_N |-> O_ADDR_SOURCE_SYNC_STROBE_N == 2'h0)
    else $error("address strobes not low in first sub-phase");
  a_sync_rise: assert property ($fell(O_ADDR_VALID_STROBE_N) |=> O_ADDR_SOURCE_SYNC_STROBE_N == 2'h3 && O_ADDR_OE)
    else $error("address strobes not high in second sub-phase");
  a_bus_release: assert property ($fell(O_ADDR_VALID_STROBE_N) |-> ##2 !O_ADDR_OE && !O_ADDR_SOURCE_SYNC_STROBE_OE)
    else $error("request lines not released after two sub-phases");
  a_stall_hold: assert property ($fell(O_ADDR_VALID_STROBE_N) |-> $past(I_BLOCK_NEXT_REQUEST_N))
    else $error("request started during a bus stall");
  a_stall_drive: assert property ($rose(I_STALL) |-> ##[1:8] !O_BLOCK_NEXT_REQUEST_N && O_BLOCK_NEXT_REQUEST_OE)
    else $error("stall line not asserted");
  a_mon_drive: assert property ($rose(I_MONITOR[1]) |-> ##[1:8] !O_BREAKPOINT_MONITOR_N[1])
    else $error("monitor line 1 not asserted");
  a_mon_enable: assert property (!O_BREAKPOINT_MONITOR_N[3] |-> O_BREAKPOINT_MONITOR_OE[1])
    else $error("monitor line 3 asserted but not driven");
  c_launch: cover property ($fell(O_ADDR_VALID_STROBE_N));
  c_stall: cover property (!I_BLOCK_NEXT_REQUEST_N);
  c_snoop: cover property (O_SNOOP_VALID);
endmodule : sysbus_request_phase_checker

bind sysbus_request_phase sysbus_request_phase_checker u_checker (.I_BCLK, .I_RSTN, .I_STALL, .I_MONITOR,
  .I_BLOCK_NEXT_REQUEST_N, .O_ADDR_OE, .O_RTYPE_OE, .O_ADDR_VALID_STROBE_N, .O_ADDR_VALID_STROBE_OE,
  .O_ADDR_SOURCE_SYNC_STROBE_N, .O_ADDR_SOURCE_SYNC_STROBE_OE, .O_BLOCK_NEXT_REQUEST_N,
  .O_BLOCK_NEXT_REQUEST_OE, .O_BREAKPOINT_MONITOR_N, .O_BREAKPOINT_MONITOR_OE, .O_SNOOP_VALID);

// ---- verification/tb_top.sv ----
// self-checking bench: core launches, foreign snoops, stalls and monitor lines
`timescale 1ns/1ps
module tb_top;
  logic I_CLOCK = 1'b0, I_BCLK = 1'b0, I_RSTN = 1'b0, I_REQ_VALID = 1'b0, I_STALL = 1'b0;
  logic f_go = 1'b0, f_stall = 1'b0;
  logic [3:0] I_MONITOR = 4'h0;
  sysbus_req_pkg::bus_req_t I_REQ = '0, f_req = '0, O_SNOOP, lq[$], sq[$];
  int errors = 0, compares = 0;
  logic [32:0] O_ADDR_N, I_ADDR_N, f_addr_n;
  logic [4:0] O_RTYPE_N, I_RTYPE_N, f_rtype_n;
  logic [3:0] O_BREAKPOINT_MONITOR_N;
  logic [1:0] O_MONITOR_IN, O_ADDR_SOURCE_SYNC_STROBE_N, O_BREAKPOINT_MONITOR_OE, I_BREAKPOINT_MONITOR_N;
  logic O_REQ_READY, O_SNOOP_VALID, O_ADDR_OE, O_RTYPE_OE, O_ADDR_VALID_STROBE_N, O_ADDR_VALID_STROBE_OE;
  logic O_ADDR_SOURCE_SYNC_STROBE_OE, O_BLOCK_NEXT_REQUEST_N, O_BLOCK_NEXT_REQUEST_OE;
  logic I_ADDR_VALID_STROBE_N, I_BLOCK_NEXT_REQUEST_N, f_drv, f_avs_n, f_stall_n;
  // lines are terminated high: an undriven line reads deasserted
  assign I_ADDR_N = O_ADDR_OE ? O_ADDR_N : (f_drv ? f_addr_n : '1);
  assign I_RTYPE_N = O_RTYPE_OE ? O_RTYPE_N : (f_drv ? f_rtype_n : '1);
  assign I_ADDR_VALID_STROBE_N = O_ADDR_VALID_STROBE_OE ? O_ADDR_VALID_STROBE_N : (f_drv ? f_avs_n : 1'b1);
  assign I_BLOCK_NEXT_REQUEST_N = (O_BLOCK_NEXT_REQUEST_N | !O_BLOCK_NEXT_REQUEST_OE) & f_stall_n;
  assign I_BREAKPOINT_MONITOR_N = {O_BREAKPOINT_MONITOR_OE[1] ? O_BREAKPOINT_MONITOR_N[3] : 1'b1,
                                   O_BREAKPOINT_MONITOR_OE[0] ? O_BREAKPOINT_MONITOR_N[0] : 1'b1};
  sysbus_request_phase DUT (.I_CLOCK, .I_RSTN, .I_BCLK, .I_REQ_VALID, .I_REQ, .O_REQ_READY, .O_SNOOP_VALID,
    .O_SNOOP, .I_STALL, .I_MONITOR, .O_MONITOR_IN, .O_ADDR_N, .O_ADDR_OE, .I_ADDR_N, .O_RTYPE_N, .O_RTYPE_OE,
    .I_RTYPE_N, .O_ADDR_VALID_STROBE_N, .O_ADDR_VALID_STROBE_OE, .I_ADDR_VALID_STROBE_N,
    .O_ADDR_SOURCE_SYNC_STROBE_N, .O_ADDR_SOURCE_SYNC_STROBE_OE, .O_BLOCK_NEXT_REQUEST_N,
    .O_BLOCK_NEXT_REQUEST_OE, .I_BLOCK_NEXT_REQUEST_N, .O_BREAKPOINT_MONITOR_N, .O_BREAKPOINT_MONITOR_OE,
    .I_BREAKPOINT_MONITOR_N);
  sysbus_far_agent far (.i_bclk(I_BCLK), .i_go(f_go), .i_stall(f_stall), .i_stall_line_n(I_BLOCK_NEXT_REQUEST_N),
    .i_req(f_req), .o_drv(f_drv), .o_avs_n(f_avs_n), .o_stall_n(f_stall_n), .o_addr_n(f_addr_n),
    .o_rtype_n(f_rtype_n));
  initial forever #20 I_CLOCK = ~I_CLOCK;
  initial begin
    #7;
    forever #15 I_BCLK = ~I_BCLK;
  end
  task automatic fail(input string m);
    errors++;
    $display("unexpected at %0t: %s", $time, m);
  endtask : fail
  task automatic cmp_req(input sysbus_req_pkg::bus_req_t g, input sysbus_req_pkg::bus_req_t e, input string m);
    compares++;
    if (g !== e) fail(m);
  endtask : cmp_req
  task automatic cmp_bits(input logic [3:0] g, input logic [3:0] e, input string m);
    compares++;
    if (g !== e) fail(m);
  endtask : cmp_bits
  task automatic test_done;
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  task automatic tick(input int n);
    repeat (n) @(posedge I_CLOCK);
    #1;
  endtask : tick
  task automatic wait_idle;
    for (int i = 0; i < 300 && (lq.size() + sq.size() != 0 || O_REQ_READY !== 1'b1); i++) tick(1);
    if (lq.size() + sq.size() != 0) fail("transfer not completed");
  endtask : wait_idle
  task automatic send(input sysbus_req_pkg::bus_req_t r);
    lq.push_back(r);
    I_REQ = r;
    I_REQ_VALID = 1'b1;
    tick(1);
    I_REQ_VALID = 1'b0;
  endtask : send
  task automatic snoop(input sysbus_req_pkg::bus_req_t r);
    sq.push_back(r);
    f_req = r;
    f_go = 1'b1;
    for (int i = 0; i < 300 && f_drv !== 1'b1; i++) tick(1);
    f_go = 1'b0;
  endtask : snoop
  function automatic sysbus_req_pkg::bus_req_t rnd();
    logic [95:0] t;
    t = {$urandom(), $urandom(), $urandom()};
    return t[70:0];
  endfunction : rnd
  // ----------------------------------------------------------------
  // result watchers
  // ----------------------------------------------------------------
  always @(posedge I_BCLK) begin : launch_watch
    sysbus_req_pkg::bus_req_t g;
    if (O_ADDR_VALID_STROBE_OE === 1'b1 && I_ADDR_VALID_STROBE_N === 1'b0) begin
      g.addr = ~I_ADDR_N;
      g.rtype = ~I_RTYPE_N;
      @(posedge I_BCLK);
      g.attr = ~I_ADDR_N;
      if (lq.size() == 0) fail("launch with nothing pending");
      else cmp_req(g, lq.pop_front(), "launched request");
    end
  end
  always @(posedge I_CLOCK) begin
    if (O_SNOOP_VALID === 1'b1) begin
      if (sq.size() == 0) fail("snoop with nothing sent");
      else cmp_req(O_SNOOP, sq.pop_front(), "snooped request");
    end
  end
  initial begin
    #200us;
    fail("watchdog expired");
    test_done();
  end
  initial begin
    void'($urandom(32'h3b9da63f));
    repeat (6) @(posedge I_CLOCK);
    #1 I_RSTN = 1'b1;
    tick(3);
    // field boundaries first, then random; each launch waits until the previous one has completed
    for (int k = 0; k < 6; k++) begin
      snoop((k == 0) ? '0 : (k == 1) ? '1 : rnd());
      wait_idle();
      send((k == 0) ? '1 : (k == 1) ? '0 : rnd());
      wait_idle();
      send(rnd());
      wait_idle();
    end
    // a stall from either agent holds back the pending launch
    for (int k = 0; k < 2; k++) begin
      if (k == 0) f_stall = 1'b1;
      else I_STALL = 1'b1;
      tick(8);
      cmp_bits({3'h0, I_BLOCK_NEXT_REQUEST_N}, 4'h0, "stall line idle");
      send(rnd());
      tick(12);
      cmp_bits(4'(lq.size()), 4'h1, "launch during stall");
      f_stall = 1'b0;
      I_STALL = 1'b0;
      wait_idle();
    end
    for (int m = 0; m < 16; m++) begin
      I_MONITOR = 4'(m);
      tick(10);
      cmp_bits(O_BREAKPOINT_MONITOR_N, ~I_MONITOR, "monitor pins");
      cmp_bits({2'h0, O_MONITOR_IN}, {2'h0, I_MONITOR[3], I_MONITOR[0]}, "monitor readback");
    end
    // mid-run reset: pins fall back to idle at once and recover after release
    I_RSTN = 1'b0;
    tick(1);
    cmp_bits(O_BREAKPOINT_MONITOR_N, sysbus_req_pkg::MON_IDLE, "monitor pins in reset");
    cmp_bits({O_BREAKPOINT_MONITOR_OE, O_BLOCK_NEXT_REQUEST_OE, O_ADDR_OE}, 4'h0, "enables in reset");
    I_RSTN = 1'b1;
    tick(10);
    cmp_bits(O_BREAKPOINT_MONITOR_N, ~I_MONITOR, "monitor pins after reset");
    test_done();
  end
endmodule : tb_top
